// [rtl/pwm_and_supply_status_regs.sv]
// spi-reached register slice: pwm2 duty, pwm rates, host scratch byte, supply fault status
`timescale 1ns/100ps
// Overview of operation
// - duty byte: zero off, ones on, else n/255
// - duty clears on reset, kept through restart
// - bit2 second, bit0 first rate; set 400Hz
// - rate register clears on reset, kept through restart
// - reserved rate bits read zero, not writable
// - scratch byte zero at power-on, survives soft reset
// - scratch written only in normal mode
// - chip logic never alters the scratch byte
// - 16-bit frame: address, mode bit, data byte
// - data byte occupies frame bits 8 to 15
// - mode zero reads status without change
// - mode one clears status register whole byte
// - status flags hold until host clear or reset; restart clears failsafe
// - status two flag positions; bits 7,5 zero
// - status two clears on reset, kept through restart
// - status one bit7 power flag, rest zero
// - restart clears repeated-undervoltage failsafe flag only
// - status one switch and second-supply flag positions
// - short flag after 4 ms below threshold
// - failsafe flag on fourth undervoltage entry
// - undervoltage flag set on main undervoltage reset
// - power flag one after power-on, zero after soft
// - undervoltage flag frozen during restart mode
module pwm_and_supply_status_regs
  import sbc_supply_pkg::*;
#(
  parameter int SHORT_CYCLES = SHORT_CYCLES_DEF
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  output logic      spi_miso,
  input  wire logic soft_reset,
  input  wire logic restart_mode,
  input  wire logic normal_mode,
  input  wire logic failsafe_uv_entry,
  input  wire logic battery_uv,
  input  wire logic third_supply_oc,
  input  wire logic third_supply_uv,
  input  wire logic third_supply_ot,
  input  wire logic main_supply_ov,
  input  wire logic main_supply_prewarn,
  input  wire logic switch_supply_uv,
  input  wire logic switch_supply_ov,
  input  wire logic second_supply_ot,
  input  wire logic second_supply_uv,
  input  wire logic main_below_reset,
  input  wire logic main_supply_on,
  output logic      second_pwm_out,
  output logic      first_pwm_rate_select,
  output logic      second_pwm_rate_select
);

  localparam logic [SHORT_CNT_W-1:0] SHORT_LIMIT = SHORT_CNT_W'(SHORT_CYCLES);

  // ---------------- link domain (spi_sclk) ----------------
  logic        frame_rst;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] rx_shift_reg;
  logic [15:0] word_reg;
  logic        frame_tgl_reg;
  logic        miso_reg;
  logic [15:0] resp_word_reg;

  // the frame's own select ends every per-frame state; short frames are dropped
  assign frame_rst = rst | spi_cs_n;

  always_ff @(posedge spi_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg  <= 5'h00;
      rx_shift_reg <= 16'h0000;
    end else if (bit_cnt_reg != FRAME_BITS) begin
      rx_shift_reg <= {spi_mosi, rx_shift_reg[15:1]};
      bit_cnt_reg  <= bit_cnt_reg + 5'h01;
    end
  end

  // word held stable until the next frame's last bit; toggle announces it
  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      word_reg      <= 16'h0000;
      frame_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == FRAME_LAST) begin
      word_reg      <= {spi_mosi, rx_shift_reg[15:1]};
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // answer of the previous command, lsb first; bit 0 is always zero
  // resp_word_reg is quasi-static here: it only changes between frames
  always_ff @(negedge spi_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      miso_reg <= 1'b0;
    end else begin
      miso_reg <= resp_word_reg[bit_cnt_reg[3:0]];
    end
  end

  assign spi_miso = miso_reg;

  // ---------------- system domain (clock) ----------------
  logic [2:0]  frame_sync_reg;
  logic        cmd_stb_reg;
  logic [6:0]  cmd_addr;
  logic        cmd_mode;
  logic [7:0]  cmd_data;
  logic        cmd_wr;
  logic        cmd_clr2;
  logic        cmd_clr1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_sync_reg <= 3'h0;
      cmd_stb_reg    <= 1'b0;
    end else begin
      frame_sync_reg <= {frame_sync_reg[1:0], frame_tgl_reg};
      cmd_stb_reg    <= frame_sync_reg[2] ^ frame_sync_reg[1];
    end
  end

  assign cmd_addr = word_reg[6:0];
  assign cmd_mode = word_reg[MODE_BIT];
  assign cmd_data = word_reg[DATA_LSB +: 8];
  assign cmd_wr   = cmd_stb_reg & cmd_mode;
  assign cmd_clr2 = cmd_wr & (cmd_addr == ADDR_STAT2);
  assign cmd_clr1 = cmd_wr & (cmd_addr == ADDR_STAT1);

  // detector levels come from the analog side, unrelated to clock
  logic [11:0] fault_raw;
  logic [11:0] fault_meta_reg;
  logic [11:0] fault_sync_reg;

  assign fault_raw = {main_supply_on, main_below_reset, switch_supply_uv, switch_supply_ov,
                      second_supply_ot, second_supply_uv, battery_uv, third_supply_oc,
                      third_supply_uv, third_supply_ot, main_supply_ov, main_supply_prewarn};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_meta_reg <= 12'h000;
      fault_sync_reg <= 12'h000;
    end else begin
      fault_meta_reg <= fault_raw;
      fault_sync_reg <= fault_meta_reg;
    end
  end

  // short detection: below threshold ever since switch-on
  logic [SHORT_CNT_W-1:0] short_cnt_reg;
  logic                   came_up_reg;
  logic                   short_set;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      short_cnt_reg <= '0;
      came_up_reg   <= 1'b0;
    end else if (!fault_sync_reg[11]) begin
      short_cnt_reg <= '0;
      came_up_reg   <= 1'b0;
    end else if (!fault_sync_reg[10]) begin
      short_cnt_reg <= '0;
      came_up_reg   <= 1'b1;
    end else if (!came_up_reg && short_cnt_reg != SHORT_LIMIT) begin
      short_cnt_reg <= short_cnt_reg + 1'b1;
    end
  end

  assign short_set = (short_cnt_reg == SHORT_LIMIT);

  // restart entry edge
  logic restart_q_reg;
  logic restart_entry;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      restart_q_reg <= 1'b0;
    end else begin
      restart_q_reg <= restart_mode;
    end
  end

  assign restart_entry = restart_mode & ~restart_q_reg;

  // flag set vectors: a present fault keeps setting its flag, except main undervoltage in restart mode
  logic [7:0] set2;
  logic [7:0] set1;
  logic       uv_set;

  assign uv_set = fault_sync_reg[10] & ~restart_mode;
  assign set2   = {1'b0, fault_sync_reg[5], 1'b0, fault_sync_reg[4:0]} & STAT2_MASK;
  assign set1   = {1'b0, fault_sync_reg[9:6], short_set, failsafe_uv_entry, uv_set};

  // registers
  logic [7:0] duty2_reg;
  logic [7:0] freq_reg;
  logic [7:0] scratch_reg;
  logic [7:0] stat2_reg;
  logic [7:0] stat1_reg;

  // restart leaves duty untouched
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      duty2_reg <= DUTY2_RST;
    end else if (soft_reset) begin
      duty2_reg <= DUTY2_RST;
    end else if (cmd_wr && cmd_addr == ADDR_DUTY2) begin
      duty2_reg <= cmd_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      freq_reg <= FREQ_RST;
    end else if (soft_reset) begin
      freq_reg <= FREQ_RST;
    end else if (cmd_wr && cmd_addr == ADDR_FREQ) begin
      freq_reg <= cmd_data & FREQ_MASK;
    end
  end

  // only the host writes this byte; soft reset, fail-safe and restart leave it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scratch_reg <= SCRATCH_RST;
    end else if (cmd_wr && cmd_addr == ADDR_SCRATCH && normal_mode) begin
      scratch_reg <= cmd_data;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat2_reg <= STAT2_RST;
    end else if (soft_reset) begin
      stat2_reg <= STAT2_RST;
    end else begin
      stat2_reg <= (stat2_reg & ~(cmd_clr2 ? STAT2_MASK : 8'h00)) | set2;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat1_reg <= STAT1_POR;
    end else if (soft_reset) begin
      stat1_reg <= STAT1_SOFT;
    end else begin
      stat1_reg <= (stat1_reg & ~(cmd_clr1 ? STAT1_MASK : 8'h00)
                    & ~(restart_entry ? (8'h01 << STAT1_FS_BIT) : 8'h00)) | set1;
    end
  end

  // read mux: value before any clear of the same command
  logic [7:0] rd_data;
  logic       rd_mapped;

  always_comb begin
    rd_data   = 8'h00;
    rd_mapped = 1'b1;
    case (cmd_addr)
      ADDR_DUTY2:   rd_data = duty2_reg;
      ADDR_FREQ:    rd_data = freq_reg & FREQ_MASK;
      ADDR_SCRATCH: rd_data = normal_mode ? scratch_reg : 8'h00;
      ADDR_STAT2:   rd_data = stat2_reg & STAT2_MASK;
      ADDR_STAT1:   rd_data = stat1_reg;
      default:      rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resp_word_reg <= RESP_RST;
    end else if (cmd_stb_reg) begin
      resp_word_reg                    <= RESP_RST;
      resp_word_reg[DATA_LSB +: 8]     <= rd_data;
      resp_word_reg[RESP_UNMAPPED_BIT] <= ~rd_mapped;
    end
  end

  // pwm generator: 255 steps per period, tick length picks the rate
  logic [11:0] tick_cnt_reg;
  logic [7:0]  step_reg;
  logic [11:0] tick_lim;
  logic        tick_end;
  logic        pwm_out_reg;

  assign tick_lim = freq_reg[FREQ2_BIT] ? PWM_TICK_FAST : PWM_TICK_SLOW;
  assign tick_end = (tick_cnt_reg >= tick_lim - 12'h001);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 12'h000;
    end else if (tick_end) begin
      tick_cnt_reg <= 12'h000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      step_reg <= 8'h00;
    end else if (tick_end) begin
      step_reg <= (step_reg >= PWM_LAST_STEP) ? 8'h00 : step_reg + 8'h01;
    end
  end

  // step never reaches 255, so 0xff is always on and 0x00 always off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_out_reg <= 1'b0;
    end else begin
      pwm_out_reg <= (step_reg < duty2_reg);
    end
  end

  assign second_pwm_out         = pwm_out_reg;
  assign first_pwm_rate_select  = freq_reg[FREQ1_BIT];
  assign second_pwm_rate_select = freq_reg[FREQ2_BIT];

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence frame_arrive_s;
    frame_sync_reg[2] != frame_sync_reg[1];
  endsequence

  sequence duty_full_s;
    (duty2_reg == 8'hff) [*2];
  endsequence

  sequence duty_zero_s;
    (duty2_reg == 8'h00) [*2];
  endsequence

  frame_commit_a: assert property (frame_arrive_s |=> cmd_stb_reg)
    else $error("frame not committed");
  pwm_full_on_a: assert property (duty_full_s |-> pwm_out_reg)
    else $error("full duty not on");
  pwm_full_off_a: assert property (duty_zero_s |-> !pwm_out_reg)
    else $error("zero duty not off");
  duty_soft_a: assert property (soft_reset |=> duty2_reg == DUTY2_RST)
    else $error("duty not cleared by soft reset");
  duty_keep_a: assert property (restart_mode && !soft_reset && !cmd_wr |=> $stable(duty2_reg))
    else $error("duty changed in restart");
  freq_reserved_a: assert property ((freq_reg & ~FREQ_MASK) == 8'h00)
    else $error("reserved rate bit set");
  freq_write_a: assert property (cmd_wr && cmd_addr == ADDR_FREQ && !soft_reset
                                 |=> freq_reg == ($past(cmd_data) & FREQ_MASK))
    else $error("rate write lost");
  scratch_guard_a: assert property (!(cmd_wr && cmd_addr == ADDR_SCRATCH && normal_mode)
                                    |=> $stable(scratch_reg))
    else $error("scratch changed without host write");
  stat2_clear_a: assert property (cmd_clr2 && set2 == 8'h00 && !soft_reset |=> stat2_reg == 8'h00)
    else $error("status two not cleared");
  stat2_reserved_a: assert property ((stat2_reg & ~STAT2_MASK) == 8'h00)
    else $error("status two reserved bit set");
  stat1_hold_a: assert property (!cmd_clr1 && !soft_reset && !restart_entry
                                 |=> (stat1_reg & $past(stat1_reg)) == $past(stat1_reg))
    else $error("status one flag dropped");
  clear_answer_a: assert property (cmd_stb_reg && cmd_addr == ADDR_STAT1
                                   |=> resp_word_reg[15:8] == $past(stat1_reg))
    else $error("clear answer not pre-clear content");
  short_flag_a: assert property (short_set && !soft_reset |=> stat1_reg[STAT1_SHORT_BIT])
    else $error("short flag not set");
  failsafe_set_a: assert property (failsafe_uv_entry && !soft_reset |=> stat1_reg[STAT1_FS_BIT])
    else $error("failsafe flag not set");
  failsafe_clear_a: assert property (restart_entry && !failsafe_uv_entry && !soft_reset
                                     |=> !stat1_reg[STAT1_FS_BIT])
    else $error("failsafe flag kept through restart");
  uv_frozen_a: assert property (restart_mode |=> !$rose(stat1_reg[STAT1_UV_BIT]))
    else $error("undervoltage flag set in restart");
  por_soft_a: assert property (soft_reset |=> stat1_reg == STAT1_SOFT)
    else $error("status one not cleared by soft reset");

endmodule

// [rtl/sbc_supply_pkg.sv]
// constants for the pwm and supply status register slice
package sbc_supply_pkg;
  // clocking
  localparam int CLK_FREQ_MHZ = 125;
  localparam int CLK_FREQ_HZ  = CLK_FREQ_MHZ * 1_000_000;

  // register addresses (7-bit, whole-word addressed)
  localparam logic [6:0] ADDR_DUTY2   = 7'h19;
  localparam logic [6:0] ADDR_FREQ    = 7'h1c;
  localparam logic [6:0] ADDR_SCRATCH = 7'h1e;
  localparam logic [6:0] ADDR_STAT2   = 7'h40;
  localparam logic [6:0] ADDR_STAT1   = 7'h41;

  // frame layout
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam int         MODE_BIT   = 7;
  localparam int         DATA_LSB   = 8;
  localparam int         RESP_UNMAPPED_BIT = 1;

  // reset values and field masks
  localparam logic [7:0] DUTY2_RST   = 8'h00;
  localparam logic [7:0] FREQ_RST    = 8'h00;
  localparam logic [7:0] FREQ_MASK   = 8'h05;
  localparam int         FREQ1_BIT   = 0;
  localparam int         FREQ2_BIT   = 2;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] STAT2_RST   = 8'h00;
  localparam logic [7:0] STAT2_MASK  = 8'h5f;
  localparam logic [7:0] STAT1_POR   = 8'h80;
  localparam logic [7:0] STAT1_SOFT  = 8'h00;
  localparam logic [7:0] STAT1_MASK  = 8'hff;
  localparam int         STAT1_SHORT_BIT = 2;
  localparam int         STAT1_FS_BIT    = 1;
  localparam int         STAT1_UV_BIT    = 0;
  localparam logic [15:0] RESP_RST   = 16'h0000;

  // main supply short detection time
  localparam int SHORT_TIME_US    = 4000;
  localparam int SHORT_CYCLES_DEF = SHORT_TIME_US * CLK_FREQ_MHZ;
  localparam int SHORT_CNT_W      = 20;

  // pwm timing: 255 steps per period, 200 Hz or 400 Hz
  localparam int         PWM_BASE_HZ   = 200;
  localparam int         PWM_STEP_NUM  = 255;
  localparam logic [11:0] PWM_TICK_SLOW = 12'(CLK_FREQ_HZ / (PWM_BASE_HZ * PWM_STEP_NUM));
  localparam logic [11:0] PWM_TICK_FAST = 12'(CLK_FREQ_HZ / (2 * PWM_BASE_HZ * PWM_STEP_NUM));
  localparam logic [7:0]  PWM_LAST_STEP = 8'(PWM_STEP_NUM - 1);
endpackage

// [sim/pwm_and_supply_status_regs_bench.sv]
// self-checking bench for the pwm and supply status register slice
`timescale 1ns/100ps
module pwm_and_supply_status_regs_bench;
  import sbc_supply_pkg::*;
  localparam int SHORT_SIM = 20;
  typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        soft_reset = 1'b0;
  logic        restart_mode = 1'b0;
  logic        normal_mode = 1'b1;
  logic        failsafe_uv_entry = 1'b0;
  logic [11:0] cause = 12'h000;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        second_pwm_out;
  logic        first_rate;
  logic        second_rate;
  logic [15:0] ans;
  logic [7:0]  pv [2] = '{8'hff, 8'h00};
  int          errors = 0;
  int          compares = 0;
  int          miss;
  row_t        rows [6] = '{'{ADDR_DUTY2, 8'hff, 8'hff}, '{ADDR_DUTY2, 8'h5a, 8'h5a},
                            '{ADDR_FREQ, 8'hff, 8'h05}, '{ADDR_FREQ, 8'h04, 8'h04},
                            '{ADDR_FREQ, 8'h01, 8'h01}, '{ADDR_SCRATCH, 8'ha5, 8'ha5}};

  always #4 clock = ~clock;

  spi_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  pwm_and_supply_status_regs #(.SHORT_CYCLES(SHORT_SIM)) uut (
    .clock(clock), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .soft_reset(soft_reset), .restart_mode(restart_mode), .normal_mode(normal_mode),
    .failsafe_uv_entry(failsafe_uv_entry), .battery_uv(cause[11]), .third_supply_oc(cause[10]),
    .third_supply_uv(cause[9]), .third_supply_ot(cause[8]), .main_supply_ov(cause[7]),
    .main_supply_prewarn(cause[6]), .switch_supply_uv(cause[5]), .switch_supply_ov(cause[4]),
    .second_supply_ot(cause[3]), .second_supply_uv(cause[2]), .main_below_reset(cause[1]),
    .main_supply_on(cause[0]), .second_pwm_out(second_pwm_out), .first_pwm_rate_select(first_rate),
    .second_pwm_rate_select(second_rate));

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // small skew keeps link edges off the system clock grid
  task automatic access(input logic [6:0] a, input logic m, input logic [7:0] d);
    #1.3;
    host.xfer({d, m, a}, 16, ans);
  endtask

  // answer of a read only shows up in the following frame
  task automatic expect_reg(input string nm, input logic [6:0] a, input logic [7:0] e);
    access(a, 1'b0, 8'h00);
    access(ADDR_FREQ, 1'b0, 8'h00);
    check(nm, ans, {e, 8'h00});
  endtask

  task automatic drive(input logic [11:0] c, input int n);
    @(negedge clock);
    cause = c;
    repeat (n) @(negedge clock);
  endtask

  task automatic pulse_failsafe();
    @(negedge clock);
    failsafe_uv_entry = 1'b1;
    @(negedge clock);
    failsafe_uv_entry = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #600us;
    errors++;
    $display("BAD watchdog expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    foreach (rows[i]) begin
      access(rows[i].a, 1'b1, rows[i].d);
      expect_reg("row readback", rows[i].a, rows[i].e);
    end
    // second power-on reset in mid-run
    @(negedge clock);
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    expect_reg("stat1 por", ADDR_STAT1, 8'h80);
    expect_reg("stat1 reread", ADDR_STAT1, 8'h80);
    expect_reg("stat2 por", ADDR_STAT2, 8'h00);
    expect_reg("duty por", ADDR_DUTY2, 8'h00);
    expect_reg("freq por", ADDR_FREQ, 8'h00);
    expect_reg("scratch por", ADDR_SCRATCH, 8'h00);
    access(ADDR_STAT1, 1'b1, 8'hff);
    access(ADDR_STAT1, 1'b0, 8'h00);
    check("stat1 clear answer", ans, 16'h8000);
    expect_reg("stat1 cleared", ADDR_STAT1, 8'h00);
    drive(12'hfc0, 6);
    drive(12'h000, 4);
    expect_reg("stat2 flags", ADDR_STAT2, 8'h5f);
    drive(12'h800, 2);
    access(ADDR_STAT2, 1'b1, 8'h00);
    expect_reg("stat2 persisting", ADDR_STAT2, 8'h40);
    drive(12'h000, 4);
    access(ADDR_STAT2, 1'b1, 8'h00);
    expect_reg("stat2 cleared", ADDR_STAT2, 8'h00);
    // short flag must wait for the full count
    drive(12'h003, 10);
    drive(12'h000, 4);
    expect_reg("stat1 brief low", ADDR_STAT1, 8'h01);
    access(ADDR_STAT1, 1'b1, 8'h00);
    drive(12'h03f, 40);
    pulse_failsafe();
    drive(12'h000, 4);
    expect_reg("stat1 flags", ADDR_STAT1, 8'h7f);
    access(ADDR_STAT1, 1'b1, 8'h00);
    drive(12'h020, 4);
    pulse_failsafe();
    drive(12'h040, 4);
    drive(12'h000, 4);
    access(ADDR_DUTY2, 1'b1, 8'h33);
    access(ADDR_FREQ, 1'b1, 8'h05);
    access(ADDR_SCRATCH, 1'b1, 8'hc3);
    check("rate selects", {14'h0000, first_rate, second_rate}, 16'h0003);
    @(negedge clock);
    restart_mode = 1'b1;
    normal_mode = 1'b0;
    drive(12'h002, 6);
    drive(12'h000, 4);
    access(ADDR_SCRATCH, 1'b1, 8'h11);
    expect_reg("stat1 restart", ADDR_STAT1, 8'h40);
    expect_reg("duty restart", ADDR_DUTY2, 8'h33);
    expect_reg("freq restart", ADDR_FREQ, 8'h05);
    expect_reg("stat2 restart", ADDR_STAT2, 8'h01);
    expect_reg("scratch hidden", ADDR_SCRATCH, 8'h00);
    @(negedge clock);
    restart_mode = 1'b0;
    normal_mode = 1'b1;
    expect_reg("scratch kept", ADDR_SCRATCH, 8'hc3);
    @(negedge clock);
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    expect_reg("duty soft", ADDR_DUTY2, 8'h00);
    expect_reg("freq soft", ADDR_FREQ, 8'h00);
    expect_reg("stat2 soft", ADDR_STAT2, 8'h00);
    expect_reg("stat1 soft", ADDR_STAT1, 8'h00);
    expect_reg("scratch soft", ADDR_SCRATCH, 8'hc3);
    check("rates soft", {14'h0000, first_rate, second_rate}, 16'h0000);
    access(7'h7f, 1'b1, 8'hff);
    access(ADDR_DUTY2, 1'b0, 8'h00);
    check("unmapped flag", {15'h0000, ans[1]}, 16'h0001);
    #1.3;
    host.xfer({8'h77, 1'b1, ADDR_DUTY2}, 8, ans);
    expect_reg("short frame", ADDR_DUTY2, 8'h00);
    foreach (pv[i]) begin
      access(ADDR_DUTY2, 1'b1, pv[i]);
      miss = 0;
      repeat (3000) begin
        @(negedge clock);
        if (second_pwm_out !== pv[i][0]) begin
          miss++;
        end
      end
      check("pwm level misses", 16'(miss), 16'h0000);
    end
    tally_and_finish();
  end
endmodule

// [sim/spi_host_model.sv]
// host side of the spi link: mode 0, lsb first, one command per frame
`timescale 1ns/100ps
module spi_host_model (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  localparam time HALF = 80ns;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // nbits below 16 gives a cut-short frame that the device must drop
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] ans);
    ans = '0;
    spi_cs_n = 1'b0;
    spi_mosi = word[0];
    #(HALF);
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = 1'b1;
      ans[i] = spi_miso;
      #(HALF);
      spi_sclk = 1'b0;
      if (i < nbits - 1) begin
        spi_mosi = word[i+1];
      end
      #(HALF);
    end
    spi_cs_n = 1'b1;
    // released line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
    // gap long enough for the device to commit the word
    #(3*HALF);
  endtask
endmodule
